// file: core/adc_converter.sv
/*
  Decimating counter behind the sigma-delta modulator. Assumes the
  modulator bit is synchronous to sys_clk and valid on working ticks.
*/
`timescale 1ns/1ns
module adc_converter #(
  parameter int CONV_TICKS = hk_adc_pkg::CONV_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic modBit,
  conv_if.conv     cif
);
  import hk_adc_pkg::*;

  localparam int TW = $clog2(WORK_DIV);
  localparam logic [TW-1:0] TICK_LAST = TW'(WORK_DIV - 1);
  localparam logic [RESULT_W-1:0] CNT_LAST = RESULT_W'(CONV_TICKS - 1);

  logic [TW-1:0]       tickCnt_reg, tickCnt_next;
  logic                active_reg, active_next;
  logic [RESULT_W-1:0] count_reg, count_next;
  logic [RESULT_W-1:0] ones_reg, ones_next;
  logic                done_reg, done_next;
  logic [RESULT_W-1:0] result_reg, result_next;
  logic                tick;

  // ****************************************
  // Working clock and decimation
  // ****************************************
  always_comb begin
    tick         = (tickCnt_reg == TICK_LAST);
    tickCnt_next = tick ? '0 : tickCnt_reg + 1'b1;
    active_next  = active_reg;
    count_next   = count_reg;
    ones_next    = ones_reg;
    done_next    = 1'b0;
    result_next  = result_reg;
    if (cif.start && !active_reg) begin
      active_next = 1'b1;
      count_next  = '0;
      ones_next   = '0;
    end else if (active_reg && tick) begin
      // Ones over CONV_TICKS ticks span 0 to CONV_TICKS (4095 by default)
      ones_next  = ones_reg + RESULT_W'(modBit);
      count_next = count_reg + 1'b1;
      if (count_reg == CNT_LAST) begin
        active_next = 1'b0;
        done_next   = 1'b1;
        result_next = ones_next;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tickCnt_reg <= '0;
      active_reg  <= 1'b0;
      count_reg   <= '0;
      ones_reg    <= '0;
      done_reg    <= 1'b0;
      result_reg  <= CODE_MIN;
    end else begin
      tickCnt_reg <= tickCnt_next;
      active_reg  <= active_next;
      count_reg   <= count_next;
      ones_reg    <= ones_next;
      done_reg    <= done_next;
      result_reg  <= result_next;
    end
  end

  assign cif.done   = done_reg;
  assign cif.result = result_reg;

  work_tick_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tick |=> !tick [*3] ##1 tick) else $error("working tick off 2.5 MHz");
  done_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    done_reg |=> !done_reg && !active_reg) else $error("done not one pulse");

endmodule

// file: core/conv_if.sv
/*
  Start/done handshake between the sequencer and the converter core.
  Assumes both ends share sys_clk.
*/
`timescale 1ns/1ns
interface conv_if;
  logic                              start;
  logic [hk_adc_pkg::CH_W-1:0]       channel;
  logic                              done;
  logic [hk_adc_pkg::RESULT_W-1:0]   result;
  modport seq  (output start, channel, input done, result);
  modport conv (input start, channel, output done, result);
endinterface

// file: core/hk_adc_pkg.sv
/*
  Constants, channel map and helper functions of the housekeeping ADC
  sequencer. Assumes a 10 MHz system clock and a 12-bit converter.
*/
package hk_adc_pkg;

  localparam int RESULT_W = 12;
  localparam int CH_W     = 3;
  localparam int SLOTS    = 2;

  localparam logic [RESULT_W-1:0] CODE_MIN = 12'h000;
  localparam logic [RESULT_W-1:0] CODE_MAX = 12'hfff;

  localparam logic [CH_W-1:0] CH_EXT_A    = 3'h0;
  localparam logic [CH_W-1:0] CH_EXT_B    = 3'h1;
  localparam logic [CH_W-1:0] CH_RESERVED = 3'h2;
  localparam logic [CH_W-1:0] CH_SUPPLY   = 3'h3;
  localparam logic [CH_W-1:0] CH_CURRENT  = 3'h4;
  localparam logic [CH_W-1:0] CH_TEMP1    = 3'h5;
  localparam logic [CH_W-1:0] CH_TEMP2    = 3'h6;
  localparam logic [CH_W-1:0] CH_TEST     = 3'h7;

  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_DIV4 = 2'h1;
  localparam logic [1:0] SCALE_DIV5 = 2'h2;

  localparam int SYS_CLK_HZ  = 10_000_000;
  localparam int WORK_CLK_HZ = 2_500_000;
  localparam int WORK_DIV    = SYS_CLK_HZ / WORK_CLK_HZ;
  localparam int CONV_TICKS  = 4095;

  localparam int SETTLE_NS  = 10_000;
  localparam int SETTLE_CYC =
    (SETTLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int AUTO_BASE_NS  = 1_000_000;
  localparam int AUTO_BASE_CYC =
    (AUTO_BASE_NS / 1000) * (SYS_CLK_HZ / 1_000_000);

  function automatic logic [1:0] scaleFor(input logic [CH_W-1:0] ch);
    case (ch)
      CH_SUPPLY: scaleFor = SCALE_DIV4;
      CH_TEST:   scaleFor = SCALE_DIV5;
      default:   scaleFor = SCALE_NONE;
    endcase
  endfunction

  function automatic logic chUsable(input logic [CH_W-1:0] ch);
    chUsable = (ch != CH_RESERVED);
  endfunction

endpackage

// file: core/housekeeping_adc_sequencer.sv
/*
  Housekeeping ADC sequencer: arbitrates software and periodic requests,
  powers the analog rail, steers the input mux and files results.
  Assumes all inputs synchronous to sys_clk and a sigma-delta modulator
  whose bit stream arrives on modBit.
*/
// Function
// - one 12-bit result per conversion, one of eight mux inputs at a time.
// - sampling and conversion run from a 2.5 MHz working tick.
// - finished software conversion raises an interrupt so the host reads the result.
// - software requests are served before periodic ones.
// - results are unsigned codes from 0 up to 4095.
// - channels 0 and 1 are the external pins unscaled; channel 2 reserved.
// - channel 3 supply divided by 4, 4 current, 5/6 temperature, 7 by 5.
// - analog rail regulator switches on only while conversions need it.
// - software request yields done interrupt and result in the result port.
// - periodic slots convert in ascending channel order, lower into slot 0.
// - threshold crossing raises interrupt and optional shutdown per slot.
// - periodic conversion never stalls; new results overwrite old ones.
`timescale 1ns/1ns
module housekeeping_adc_sequencer #(
  parameter int CONV_TICKS    = hk_adc_pkg::CONV_TICKS,
  parameter int AUTO_BASE_CYC = hk_adc_pkg::AUTO_BASE_CYC,
  parameter int PERIOD_W      = 24
) (
  input  wire logic                               sys_clk,
  input  wire logic                               rst_b,
  input  wire logic                               swStart,
  input  wire logic [hk_adc_pkg::CH_W-1:0]        swRequestSelect,
  input  wire logic [1:0]                         periodicEnable,
  input  wire logic [1:0]                         periodicControl,
  input  wire logic [hk_adc_pkg::CH_W-1:0]        periodicSlot0Channel,
  input  wire logic [hk_adc_pkg::CH_W-1:0]        periodicSlot1Channel,
  input  wire logic [hk_adc_pkg::RESULT_W-1:0]    threshold0,
  input  wire logic [hk_adc_pkg::RESULT_W-1:0]    threshold1,
  input  wire logic [1:0]                         thresholdAbove,
  input  wire logic [1:0]                         shutdownEnable,
  input  wire logic                               modBit,
  output logic                                    analogRailRegulatorEn,
  output logic [hk_adc_pkg::CH_W-1:0]             muxSel,
  output logic                                    muxEnable,
  output logic [1:0]                              scalerSel,
  output logic [hk_adc_pkg::RESULT_W-1:0]         swResult,
  output logic                                    swConversionDoneIrq,
  output logic [hk_adc_pkg::RESULT_W-1:0]         autoResult0,
  output logic [hk_adc_pkg::RESULT_W-1:0]         autoResult1,
  output logic                                    thresholdIrq,
  output logic                                    shutdownReq
);
  import hk_adc_pkg::*;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETTLE, SEQ_START, SEQ_WAIT}
    seq_state_type;

  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYC - 1);

  conv_if cif ();

  seq_state_type     state_reg, state_next;
  logic [SW-1:0]     settle_reg, settle_next;
  logic              swPend_reg, swPend_next;
  logic [CH_W-1:0]   swCh_reg, swCh_next;
  logic              autoPend_reg, autoPend_next;
  logic [PERIOD_W-1:0] period_reg, period_next;
  logic              secondPend_reg, secondPend_next;
  logic [CH_W-1:0]   secondCh_reg, secondCh_next;
  logic              curSw_reg, curSw_next;
  logic              curSlot_reg, curSlot_next;
  logic [CH_W-1:0]   curCh_reg, curCh_next;
  logic              start_reg, start_next;
  logic              railEn_reg, railEn_next;
  logic              muxEn_reg, muxEn_next;
  logic [1:0]        scale_reg, scale_next;
  logic [31:0]       periodLimit;
  logic [CH_W-1:0]   loCh, hiCh;

  // ****************************************
  // Request arbitration and sequencing
  // ****************************************
  always_comb begin
    state_next      = state_reg;
    settle_next     = settle_reg;
    swCh_next       = swStart ? swRequestSelect : swCh_reg;
    period_next     = period_reg + 1'b1;
    autoPend_next   = autoPend_reg;
    secondPend_next = secondPend_reg;
    secondCh_next   = secondCh_reg;
    curSw_next      = curSw_reg;
    curSlot_next    = curSlot_reg;
    curCh_next      = curCh_reg;
    start_next      = 1'b0;
    muxEn_next      = muxEn_reg;
    scale_next      = scale_reg;
    periodLimit     = 32'(AUTO_BASE_CYC) << periodicControl;
    loCh = (periodicSlot0Channel <= periodicSlot1Channel) ?
           periodicSlot0Channel : periodicSlot1Channel;
    hiCh = (periodicSlot0Channel <= periodicSlot1Channel) ?
           periodicSlot1Channel : periodicSlot0Channel;
    // Set wins over clear: a new request in the taking cycle survives
    swPend_next = swStart | swPend_reg;
    // Period keeps running whatever the host has not serviced
    if (periodicEnable == 2'b00) begin
      period_next = '0;
    end else if (32'(period_reg) >= periodLimit - 32'd1) begin
      period_next   = '0;
      autoPend_next = 1'b1;
    end
    case (state_reg)
      SEQ_IDLE: begin
        muxEn_next = 1'b0;
        if (swPend_reg || autoPend_reg) begin
          state_next  = SEQ_SETTLE;
          settle_next = '0;
        end
      end
      SEQ_SETTLE: begin
        settle_next = settle_reg + 1'b1;
        if (settle_reg == SETTLE_LAST) begin
          state_next = SEQ_START;
        end
      end
      SEQ_START: begin
        state_next = SEQ_WAIT;
        start_next = 1'b1;
        if (swPend_reg) begin
          curSw_next  = 1'b1;
          curCh_next  = swCh_reg;
          swPend_next = swStart;
        end else if (secondPend_reg) begin
          curSw_next      = 1'b0;
          curSlot_next    = 1'b1;
          curCh_next      = secondCh_reg;
          secondPend_next = 1'b0;
        end else if (autoPend_reg && periodicEnable != 2'b00) begin
          curSw_next    = 1'b0;
          autoPend_next = (period_next == '0) && (period_reg != '0);
          if (periodicEnable == 2'b11) begin
            curSlot_next    = 1'b0;
            curCh_next      = loCh;
            secondPend_next = 1'b1;
            secondCh_next   = hiCh;
          end else begin
            curSlot_next = periodicEnable[1];
            curCh_next   = periodicEnable[1] ? periodicSlot1Channel :
                                               periodicSlot0Channel;
          end
        end else begin
          // Nothing left: drop the rail and any stale periodic request
          state_next    = SEQ_IDLE;
          start_next    = 1'b0;
          autoPend_next = 1'b0;
        end
        muxEn_next = start_next && chUsable(curCh_next);
        scale_next = scaleFor(curCh_next);
      end
      SEQ_WAIT: begin
        if (cif.done) begin
          state_next = SEQ_START;
        end
      end
      default: state_next = SEQ_IDLE;
    endcase
    railEn_next = (state_next != SEQ_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg      <= SEQ_IDLE;
      settle_reg     <= '0;
      swPend_reg     <= 1'b0;
      swCh_reg       <= CH_EXT_A;
      autoPend_reg   <= 1'b0;
      period_reg     <= '0;
      secondPend_reg <= 1'b0;
      secondCh_reg   <= CH_EXT_A;
      curSw_reg      <= 1'b0;
      curSlot_reg    <= 1'b0;
      curCh_reg      <= CH_EXT_A;
      start_reg      <= 1'b0;
      railEn_reg     <= 1'b0;
      muxEn_reg      <= 1'b0;
      scale_reg      <= SCALE_NONE;
    end else begin
      state_reg      <= state_next;
      settle_reg     <= settle_next;
      swPend_reg     <= swPend_next;
      swCh_reg       <= swCh_next;
      autoPend_reg   <= autoPend_next;
      period_reg     <= period_next;
      secondPend_reg <= secondPend_next;
      secondCh_reg   <= secondCh_next;
      curSw_reg      <= curSw_next;
      curSlot_reg    <= curSlot_next;
      curCh_reg      <= curCh_next;
      start_reg      <= start_next;
      railEn_reg     <= railEn_next;
      muxEn_reg      <= muxEn_next;
      scale_reg      <= scale_next;
    end
  end

  assign cif.start = start_reg;
  assign cif.channel = curCh_reg;

  adc_converter #(.CONV_TICKS(CONV_TICKS)) u_conv (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .modBit  (modBit),
    .cif     (cif)
  );

  // ****************************************
  // Result filing and events
  // ****************************************
  logic [RESULT_W-1:0] swRes_reg, swRes_next;
  logic [RESULT_W-1:0] auto0_reg, auto0_next, auto1_reg, auto1_next;
  logic swIrq_reg, swIrq_next, thrIrq_reg, thrIrq_next;
  logic shut_reg, shut_next, crossed;
  logic [RESULT_W-1:0] thr;

  always_comb begin
    swRes_next = swRes_reg;
    auto0_next = auto0_reg;
    auto1_next = auto1_reg;
    swIrq_next = 1'b0;
    thrIrq_next = 1'b0;
    shut_next  = 1'b0;
    thr        = curSlot_reg ? threshold1 : threshold0;
    // Reaching the threshold counts as crossing it
    crossed    = thresholdAbove[curSlot_reg] ? (cif.result >= thr) :
                                               (cif.result <= thr);
    if (cif.done && curSw_reg) begin
      swRes_next = cif.result;
      swIrq_next = 1'b1;
    end else if (cif.done) begin
      if (curSlot_reg) begin
        auto1_next = cif.result;
      end else begin
        auto0_next = cif.result;
      end
      thrIrq_next = crossed;
      shut_next   = crossed && shutdownEnable[curSlot_reg];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      swRes_reg  <= CODE_MIN;
      auto0_reg  <= CODE_MIN;
      auto1_reg  <= CODE_MIN;
      swIrq_reg  <= 1'b0;
      thrIrq_reg <= 1'b0;
      shut_reg   <= 1'b0;
    end else begin
      swRes_reg  <= swRes_next;
      auto0_reg  <= auto0_next;
      auto1_reg  <= auto1_next;
      swIrq_reg  <= swIrq_next;
      thrIrq_reg <= thrIrq_next;
      shut_reg   <= shut_next;
    end
  end

  assign analogRailRegulatorEn = railEn_reg;
  assign muxSel              = curCh_reg;
  assign muxEnable           = muxEn_reg;
  assign scalerSel           = scale_reg;
  assign swResult            = swRes_reg;
  assign swConversionDoneIrq = swIrq_reg;
  assign autoResult0         = auto0_reg;
  assign autoResult1         = auto1_reg;
  assign thresholdIrq        = thrIrq_reg;
  assign shutdownReq         = shut_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sw_done_irq_a: assert property (cif.done && curSw_reg |=>
    swIrq_reg && swRes_reg == $past(cif.result)) else $error("sw result");
  sw_first_a: assert property (state_reg == SEQ_START && swPend_reg |=>
    curSw_reg && start_reg) else $error("sw not first");
  rail_on_a: assert property (start_reg |-> railEn_reg ##1 railEn_reg)
    else $error("rail off while converting");
  reserved_mux_a: assert property (muxEn_reg |-> curCh_reg != CH_RESERVED)
    else $error("reserved channel enabled");
  supply_scale_a: assert property ($rose(start_reg) && curCh_reg ==
    CH_SUPPLY |-> scale_reg == SCALE_DIV4) else $error("scaler");
  ascending_a: assert property (state_reg == SEQ_START && !swPend_reg &&
    !secondPend_reg && autoPend_reg && periodicEnable == 2'b11 |=>
    curCh_reg <= secondCh_reg && !curSlot_reg) else $error("order");
  slot0_store_a: assert property (cif.done && !curSw_reg && !curSlot_reg
    |=> auto0_reg == $past(cif.result)) else $error("overwrite");
  shutdown_irq_a: assert property (shut_reg |-> thrIrq_reg &&
    shutdownEnable[curSlot_reg]) else $error("shutdown alone");
  sw_holds_a: assert property (state_reg == SEQ_WAIT && curSw_reg &&
    !cif.done |=> curSw_reg && !start_reg) else $error("auto cut in");
  mux_channel_a: assert property (start_reg |-> muxEn_reg ==
    (curCh_reg != CH_RESERVED)) else $error("mux enable off at start");

  sw_done_c: cover property (swIrq_reg);
  threshold_c: cover property (thrIrq_reg ##1 !thrIrq_reg);
  second_slot_c: cover property (cif.done && curSlot_reg && !curSw_reg);
  sw_over_auto_c: cover property (swPend_reg && autoPend_reg &&
    state_reg == SEQ_START);

endmodule

// file: verif/modulator_model.sv
/*
  Behavioural sigma-delta modulator seen by the sequencer: one fixed
  bit level per mux channel. Assumes the bench sets chanLevel and that
  modBit is sampled on rising sys_clk edges.
*/
`timescale 1ns/1ns
module modulator_model (
  input  wire logic                        sys_clk,
  input  wire logic [hk_adc_pkg::CH_W-1:0] muxSel,
  input  wire logic                        muxEnable,
  input  wire logic [7:0]                  chanLevel,
  output logic                             modBit
);
  import hk_adc_pkg::*;

  logic flipReg = 1'b0;

  // ************************************************
  // Bit stream
  // ************************************************
  // Mux off: a changing pattern, never a stale level
  always @(posedge sys_clk) begin
    flipReg <= ~flipReg;
  end

  // Constant level gives code 0 or full scale
  assign modBit = muxEnable ? chanLevel[muxSel] : flipReg;
endmodule

// file: verif/test_housekeeping_adc_sequencer.sv
/*
  Self-checking bench of the housekeeping ADC sequencer with shortened
  conversion and period counts. Assumes the modulator model beside it.
*/
`timescale 1ns/1ns
module test_housekeeping_adc_sequencer;
  import hk_adc_pkg::*;

  localparam int TICKS = 15;
  localparam int BASE  = 300;

  logic sys_clk = 1'b0, rst_b = 1'b0, swStart = 1'b0, modBit;
  logic [CH_W-1:0]     swRequestSelect = '0, slot0Ch = '0, slot1Ch = '0;
  logic [1:0]          periodicEnable = '0, periodicControl = '0;
  logic [1:0]          thresholdAbove = '0, shutdownEnable = '0;
  logic [RESULT_W-1:0] threshold0 = '0, threshold1 = '0;
  logic                analogRailRegulatorEn, muxEnable;
  logic [CH_W-1:0]     muxSel, lastSel = '0;
  logic [1:0]          scalerSel;
  logic [RESULT_W-1:0] swResult, autoResult0, autoResult1;
  logic                swConversionDoneIrq, thresholdIrq, shutdownReq;
  logic [7:0]          chanLevel = '0;
  logic [CH_W-1:0]     selLog[$];
  int errors = 0, samples_checked = 0, seed = 96;
  int thrCount = 0, sdCount = 0, swCount = 0, pairBad = 0, n;

  always #50 sys_clk = ~sys_clk;

  housekeeping_adc_sequencer #(.CONV_TICKS(TICKS), .AUTO_BASE_CYC(BASE)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .swStart(swStart),
    .swRequestSelect(swRequestSelect), .periodicEnable(periodicEnable),
    .periodicControl(periodicControl), .periodicSlot0Channel(slot0Ch),
    .periodicSlot1Channel(slot1Ch), .threshold0(threshold0),
    .threshold1(threshold1), .thresholdAbove(thresholdAbove),
    .shutdownEnable(shutdownEnable), .modBit(modBit),
    .analogRailRegulatorEn(analogRailRegulatorEn), .muxSel(muxSel),
    .muxEnable(muxEnable), .scalerSel(scalerSel), .swResult(swResult),
    .swConversionDoneIrq(swConversionDoneIrq), .autoResult0(autoResult0),
    .autoResult1(autoResult1), .thresholdIrq(thresholdIrq),
    .shutdownReq(shutdownReq));

  modulator_model partner (
    .sys_clk(sys_clk), .muxSel(muxSel), .muxEnable(muxEnable),
    .chanLevel(chanLevel), .modBit(modBit));

  // ************************************************
  // Monitor of pulses and mux order
  // ************************************************
  always @(posedge sys_clk) begin
    if (thresholdIrq === 1'b1) thrCount++;
    if (shutdownReq === 1'b1) sdCount++;
    if (swConversionDoneIrq === 1'b1) swCount++;
    if (shutdownReq === 1'b1 && thresholdIrq !== 1'b1) pairBad++;
    if (muxSel !== lastSel) begin
      selLog.push_back(muxSel);
      lastSel = muxSel;
    end
  end

  // ************************************************
  // Expectations and helpers
  // ************************************************
  function automatic logic [RESULT_W-1:0] expCode(input logic [CH_W-1:0] c);
    expCode = chanLevel[c] ? RESULT_W'(TICKS) : '0;
  endfunction

  function automatic logic [1:0] expScale(input logic [CH_W-1:0] c);
    expScale = (c == 3'h3) ? SCALE_DIV4 : (c == 3'h7) ? SCALE_DIV5 : SCALE_NONE;
  endfunction

  task automatic checkVal(input string what, input logic [31:0] seen,
                          input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic waitSwDone();
    n = 0;
    while (swConversionDoneIrq !== 1'b1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic swConvert(input logic [CH_W-1:0] c);
    logic       seenEn;
    logic       seenRail;
    logic [1:0] sc;
    seenEn = 1'b0;
    seenRail = 1'b0;
    sc = 2'h3;
    checkVal("rail idle", analogRailRegulatorEn, 1'b0);
    swRequestSelect = c;
    swStart = 1'b1;
    @(negedge sys_clk);
    swStart = 1'b0;
    n = 0;
    while (swConversionDoneIrq !== 1'b1 && n < 1000) begin
      if (muxEnable === 1'b1 && !seenEn) sc = scalerSel;
      seenEn |= (muxEnable === 1'b1);
      seenRail |= (analogRailRegulatorEn === 1'b1);
      @(negedge sys_clk);
      n++;
    end
    checkVal("sw done", n < 1000, 1'b1);
    checkVal("rail on", seenRail, 1'b1);
    checkVal("mux sel", muxSel, c);
    checkVal("mux enable", seenEn, c != CH_RESERVED);
    if (c != CH_RESERVED) begin
      checkVal("scaler", sc, expScale(c));
      checkVal("sw result", swResult, expCode(c));
    end
    repeat (20) @(negedge sys_clk);
    checkVal("rail off", analogRailRegulatorEn, 1'b0);
  endtask

  task automatic waitThr();
    n = 0;
    while (thrCount == 0 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #6000000;
    errors++;
    wrap_up();
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    chanLevel = 8'($random(seed));
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    checkVal("reset result", swResult, 12'h000);
    for (int i = 0; i < 8; i++) swConvert(CH_W'(i));
    repeat (4) swConvert(CH_W'($random(seed)));
    // Second request while the first is still pending, before settle, only replaces the channel
    swCount = 0;
    swRequestSelect = 3'h0;
    swStart = 1'b1;
    @(negedge sys_clk);
    swRequestSelect = 3'h5;
    @(negedge sys_clk);
    swStart = 1'b0;
    waitSwDone();
    checkVal("merged result", swResult, expCode(3'h5));
    repeat (600) @(negedge sys_clk);
    checkVal("merged count", swCount, 1);
    // Slots given out of order; lower channel still lands in slot 0
    chanLevel[1] = 1'b1;
    chanLevel[6] = 1'b0;
    slot0Ch = 3'h6;
    slot1Ch = 3'h1;
    threshold0 = RESULT_W'(TICKS);
    threshold1 = 12'h001;
    thresholdAbove = 2'b11;
    shutdownEnable = 2'b11;
    thrCount = 0;
    sdCount = 0;
    periodicEnable = 2'b11;
    waitThr();
    repeat (200) @(negedge sys_clk);
    checkVal("slot0 result", autoResult0, RESULT_W'(TICKS));
    checkVal("slot1 result", autoResult1, 12'h000);
    chanLevel[1] = 1'b0;
    chanLevel[6] = 1'b1;
    repeat (700) @(negedge sys_clk);
    checkVal("slot0 new", autoResult0, 12'h000);
    checkVal("slot1 new", autoResult1, RESULT_W'(TICKS));
    checkVal("irq seen", thrCount > 0, 1'b1);
    checkVal("shutdown pairs", sdCount, thrCount);
    periodicEnable = 2'b00;
    repeat (300) @(negedge sys_clk);
    // Single slot, below polarity, shutdown off for that slot
    chanLevel[3] = 1'b0;
    slot1Ch = 3'h3;
    threshold1 = 12'h000;
    thresholdAbove = 2'b00;
    shutdownEnable = 2'b01;
    thrCount = 0;
    sdCount = 0;
    periodicEnable = 2'b10;
    waitThr();
    repeat (3) @(negedge sys_clk);
    checkVal("below irq", thrCount > 0, 1'b1);
    checkVal("no shutdown", sdCount, 0);
    checkVal("slot1 only", autoResult1, 12'h000);
    periodicEnable = 2'b00;
    repeat (300) @(negedge sys_clk);
    // Software request arriving mid-sequence is served between the slots
    swConvert(3'h0);
    slot0Ch = 3'h4;
    slot1Ch = 3'h1;
    periodicEnable = 2'b11;
    selLog.delete();
    n = 0;
    while (!(muxSel === 3'h1 && muxEnable === 1'b1) && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    swRequestSelect = 3'h7;
    swStart = 1'b1;
    @(negedge sys_clk);
    swStart = 1'b0;
    n = 0;
    while (selLog.size() < 3 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    periodicEnable = 2'b00;
    selLog.push_back(3'h2);
    selLog.push_back(3'h2);
    selLog.push_back(3'h2);
    checkVal("first conv", selLog[0], 3'h1);
    checkVal("sw between", selLog[1], 3'h7);
    checkVal("second conv", selLog[2], 3'h4);
    checkVal("sw seq result", swResult, expCode(3'h7));
    checkVal("pulse pairing", pairBad, 0);
    wrap_up();
  end
endmodule
